// ==== rtw_cfg.svh ====
// Constants of the ripple timer with periodic interrupt and watchdog
`ifndef RTW_CFG_SVH
`define RTW_CFG_SVH

// Register indices, byte address is four times the index
`define RTW_IDX_CTRL      10'h008
`define RTW_IDX_COUNT     10'h009
`define RTW_IDX_SERVICE   10'h3f0

// Bit positions of timer_status_control
`define RTW_BIT_OVF_FLAG  7
`define RTW_BIT_PER_FLAG  6
`define RTW_BIT_OVF_IE    5
`define RTW_BIT_PER_IE    4
`define RTW_BIT_OVF_ACK   3
`define RTW_BIT_PER_ACK   2
`define RTW_BIT_RATE_HI   1
`define RTW_BIT_RATE_LO   0

// Bit position of the watchdog clear bit in the service location
`define RTW_BIT_WD_CLEAR  0

// Reset value of the periodic rate select, slowest rate
`define RTW_RATE_RESET    2'h3

// Chain layout: two prescale bits, eight counter bits, then the upper stages
`define RTW_CHAIN_W       17
`define RTW_CNT_LSB       2
`define RTW_CNT_MSB       9
`define RTW_PRESCALE_MAX  2'h3
`define RTW_PER_BASE_W    5'h0e

// Watchdog divider width and the count of periodic intervals to time out
`define RTW_WD_W          4
`define RTW_WD_TIMEOUT    4'h8

// Power-on and stop-exit delay in clock cycles, long and short option
`define RTW_DELAY_W       12
`define RTW_DELAY_LONG    12'hfe0
`define RTW_DELAY_SHORT   12'h010

`endif

// ==== rtw_pkg.sv ====
// Types of the ripple timer with periodic interrupt and watchdog
`default_nettype none

package rtw_pkg;

  // Phase of one bus access
  typedef enum logic [1:0] {
    RTW_BUS_IDLE,
    RTW_BUS_TAKEN,
    RTW_BUS_ANSWER
  } rtw_bus_t;

  // Periodic rate select field
  typedef logic [1:0] rtw_rate_t;

endpackage : rtw_pkg

`default_nettype wire

// ==== rtw_timer.sv ====
// Ripple timer chain with overflow, periodic interrupt, power-on delay and watchdog
//
// Function
// RULE1: Counter advances once every four clocks
// RULE2: Chain keeps running in wait and halt
// RULE3: Counter readable anytime without disturbing it
// RULE4: Overflow flag sets on counter wrap
// RULE5: Interrupt while overflow flag and enable set
// RULE6: Overflow ack clears flag, flag write ignored
// RULE7: Acknowledge bits two, three read zero
// RULE8: Periodic flag sets on tap, requests interrupt
// RULE9: Periodic ack clears flag, flag write ignored
// RULE10: Taps from divide 16384 to 131072
// RULE11: Reset sets both rate select bits
// RULE12: Rate change may drop or add event
// RULE13: Software services watchdog before rate change
// RULE14: Watchdog times out after eight periodic intervals
// RULE15: Watchdog timeout raises internal reset request
// RULE16: Writing zero clears only watchdog divider
// RULE17: Service location reads user byte, no reset
// RULE18: Watchdog present by build option
// RULE19: Power-on delay, then chain cleared again
// RULE20: Reset clears counter, flags, enables
// RULE21: Chain held powered down in stop
// RULE22: Stop exit delay, then counter cleared
// RULE23: Fixed bit layout of status/control register
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rtw_cfg.svh"

module rtw_timer
  import rtw_pkg::*;
#(
  parameter bit WD_PRESENT = 1'b1,
  parameter bit LONG_DELAY = 1'b1
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Avalon-MM slave
  input  wire logic [11:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output var  logic [31:0] readdata,
  output var  logic        waitrequest,
  // Device mode and user byte programming
  input  wire logic        stop_mode,
  input  wire logic        user_byte_load,
  input  wire logic [7:0]  user_byte_data,
  // Requests to the device
  output var  logic        timer_irq,
  output var  logic        chip_reset_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam logic [11:0] ADDR_CTRL    = {`RTW_IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_COUNT   = {`RTW_IDX_COUNT, 2'h0};
  localparam logic [11:0] ADDR_SERVICE = {`RTW_IDX_SERVICE, 2'h0};
  localparam logic [`RTW_DELAY_W-1:0] DELAY_CYCLES =
    LONG_DELAY ? `RTW_DELAY_LONG : `RTW_DELAY_SHORT;

  rtw_bus_t                   bus_ff;
  rtw_bus_t                   nxt_bus;
  logic [31:0]                readdata_ff;
  logic                       waitrequest_ff;
  logic [`RTW_CHAIN_W-1:0]    chain_ff;
  logic [`RTW_CHAIN_W-1:0]    per_mask;
  logic [`RTW_DELAY_W-1:0]    delay_cnt_ff;
  logic                       delay_ff;
  logic                       por_phase_ff;
  logic                       overflow_flag_ff;
  logic                       periodic_flag_ff;
  logic                       overflow_irq_enable_ff;
  logic                       periodic_irq_enable_ff;
  rtw_rate_t                  periodic_rate_select_ff;
  logic [`RTW_WD_W-1:0]       wd_cnt_ff;
  logic                       wd_fire;
  logic                       timer_irq_ff;
  logic                       chip_reset_req_ff;
  logic [7:0]                 user_byte;
  logic                       commit_wr;
  logic                       wr_ctrl;
  logic                       wr_service;
  logic                       delay_done;
  logic                       chain_clear;
  logic                       ovf_hit;
  logic                       per_hit;
  logic                       wd_clear;
  logic [7:0]                 ctrl_view;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: take, then answer two cycles later with waitrequest low

  // Phase sequencing of one access
  always_comb begin
    nxt_bus = bus_ff;
    unique case (bus_ff)
      RTW_BUS_IDLE:   if (read || write) nxt_bus = RTW_BUS_TAKEN;
      RTW_BUS_TAKEN:  nxt_bus = RTW_BUS_ANSWER;
      RTW_BUS_ANSWER: nxt_bus = RTW_BUS_IDLE;
      default:        nxt_bus = RTW_BUS_IDLE;                       // Unused code falls back to idle
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      bus_ff <= RTW_BUS_IDLE;
    end else begin
      bus_ff <= nxt_bus;
    end
  end

  // Waitrequest drops only for the answer cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      waitrequest_ff <= 1'b1;
    end else begin
      waitrequest_ff <= (nxt_bus != RTW_BUS_ANSWER);
    end
  end

  // Write strobes take effect at the edge where waitrequest is seen low
  assign commit_wr  = write && !waitrequest_ff && byteenable[0];
  assign wr_ctrl    = commit_wr && (address == ADDR_CTRL);
  assign wr_service = commit_wr && (address == ADDR_SERVICE);

  // Status view with acknowledge positions reading zero
  always_comb begin
    ctrl_view                   = 8'h00;                            // see RULE7
    ctrl_view[`RTW_BIT_OVF_FLAG] = overflow_flag_ff;                 // see RULE23
    ctrl_view[`RTW_BIT_PER_FLAG] = periodic_flag_ff;
    ctrl_view[`RTW_BIT_OVF_IE]   = overflow_irq_enable_ff;
    ctrl_view[`RTW_BIT_PER_IE]   = periodic_irq_enable_ff;
    ctrl_view[`RTW_BIT_RATE_HI]  = periodic_rate_select_ff[1];
    ctrl_view[`RTW_BIT_RATE_LO]  = periodic_rate_select_ff[0];
  end

  // Read data captured while the answer is prepared; unmapped reads give zero
  always_ff @(posedge clock) begin
    if (!resetn) begin
      readdata_ff <= 32'h0000_0000;
    end else if (bus_ff == RTW_BUS_TAKEN && read) begin
      if (address == ADDR_CTRL) begin
        readdata_ff <= {24'h00_0000, ctrl_view};
      end else if (address == ADDR_COUNT) begin
        readdata_ff <= {24'h00_0000, chain_ff[`RTW_CNT_MSB:`RTW_CNT_LSB]}; // see RULE3
      end else if (address == ADDR_SERVICE) begin
        readdata_ff <= {24'h00_0000, user_byte};                    // see RULE17
      end else begin
        readdata_ff <= 32'h0000_0000;
      end
    end
  end

  // User byte, untouched by any reset
  rtw_user_byte rtw_user_byte_inst (
    .clock      (clock),
    .load       (user_byte_load),
    .load_data  (user_byte_data),
    .rd_en      (read),
    .rd_data_ff (user_byte)                                         // see RULE17
  );

  ////////////////////////////////////////////////////////////////////////////
  // Power-on and stop-exit delay

  assign delay_done = delay_ff && !stop_mode && (delay_cnt_ff == DELAY_CYCLES - 1'b1);

  // Delay runs after reset and after each stop exit
  always_ff @(posedge clock) begin
    if (!resetn) begin
      delay_ff     <= 1'b1;                                         // see RULE19
      delay_cnt_ff <= '0;
    end else if (stop_mode) begin
      delay_ff     <= 1'b1;                                         // see RULE22
      delay_cnt_ff <= '0;
    end else if (delay_done) begin
      delay_ff     <= 1'b0;
      delay_cnt_ff <= '0;
    end else if (delay_ff) begin
      delay_cnt_ff <= delay_cnt_ff + 1'b1;
    end
  end

  // Power-on phase holds the device in reset until the delay ends
  always_ff @(posedge clock) begin
    if (!resetn) begin
      por_phase_ff <= 1'b1;
    end else if (delay_done) begin
      por_phase_ff <= 1'b0;                                         // see RULE19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ripple chain: prescale, counter and periodic stages

  // Chain cleared in stop and once more when a delay ends
  assign chain_clear = stop_mode || delay_done;                     // see RULE21

  // Free-running, not gated by CPU wait or halt
  always_ff @(posedge clock) begin
    if (!resetn || chain_clear) begin
      chain_ff <= '0;                                               // see RULE20
    end else begin
      chain_ff <= chain_ff + 1'b1;                                  // see RULE1 see RULE2
    end
  end

  // Counter wraps when the low ten chain bits are all ones
  assign ovf_hit = !chain_clear && (&chain_ff[`RTW_CNT_MSB:0]);     // see RULE4

  // Selected tap closes every 2^14 to 2^17 clocks
  assign per_mask = ~({`RTW_CHAIN_W{1'b1}} << (`RTW_PER_BASE_W + {3'h0, periodic_rate_select_ff})); // see RULE10
  assign per_hit  = !chain_clear && ((chain_ff & per_mask) == per_mask); // see RULE12

  ////////////////////////////////////////////////////////////////////////////
  // Status/control register

  // Overflow flag: set wins over acknowledge, direct writes ignored
  always_ff @(posedge clock) begin
    if (!resetn) begin
      overflow_flag_ff <= 1'b0;
    end else if (ovf_hit) begin
      overflow_flag_ff <= 1'b1;                                     // see RULE4
    end else if (wr_ctrl && writedata[`RTW_BIT_OVF_ACK]) begin
      overflow_flag_ff <= 1'b0;                                     // see RULE6
    end
  end

  // Periodic flag: set wins over acknowledge, direct writes ignored
  always_ff @(posedge clock) begin
    if (!resetn) begin
      periodic_flag_ff <= 1'b0;
    end else if (per_hit) begin
      periodic_flag_ff <= 1'b1;                                     // see RULE8
    end else if (wr_ctrl && writedata[`RTW_BIT_PER_ACK]) begin
      periodic_flag_ff <= 1'b0;                                     // see RULE9
    end
  end

  // Enables and rate select
  always_ff @(posedge clock) begin
    if (!resetn) begin
      overflow_irq_enable_ff  <= 1'b0;                              // see RULE20
      periodic_irq_enable_ff  <= 1'b0;
      periodic_rate_select_ff <= `RTW_RATE_RESET;                   // see RULE11
    end else if (wr_ctrl) begin
      overflow_irq_enable_ff  <= writedata[`RTW_BIT_OVF_IE];        // see RULE23
      periodic_irq_enable_ff  <= writedata[`RTW_BIT_PER_IE];
      periodic_rate_select_ff <= writedata[`RTW_BIT_RATE_HI:`RTW_BIT_RATE_LO];
    end
  end

  // Interrupt request from either enabled flag
  always_ff @(posedge clock) begin
    if (!resetn) begin
      timer_irq_ff <= 1'b0;
    end else begin
      timer_irq_ff <= (overflow_flag_ff && overflow_irq_enable_ff) ||  // see RULE5
                      (periodic_flag_ff && periodic_irq_enable_ff);     // see RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog

  // Servicing writes zero to the clear bit
  assign wd_clear = wr_service && !writedata[`RTW_BIT_WD_CLEAR];    // see RULE16
  assign wd_fire  = WD_PRESENT && per_hit && !wd_clear &&
                    (wd_cnt_ff == `RTW_WD_TIMEOUT - 1'b1);          // see RULE14 see RULE18

  // Final divider counts periodic intervals; only it is cleared by servicing
  always_ff @(posedge clock) begin
    if (!resetn || !WD_PRESENT || stop_mode || wd_clear || wd_fire) begin
      wd_cnt_ff <= '0;                                              // see RULE16
    end else if (per_hit) begin
      wd_cnt_ff <= wd_cnt_ff + 1'b1;                                // see RULE14
    end
  end

  // Internal reset during power-on phase and on a watchdog timeout
  always_ff @(posedge clock) begin
    if (!resetn) begin
      chip_reset_req_ff <= 1'b1;
    end else begin
      chip_reset_req_ff <= por_phase_ff || wd_fire;                 // see RULE15 see RULE19
    end
  end

  // Outputs straight from their flops
  assign readdata       = readdata_ff;
  assign waitrequest    = waitrequest_ff;
  assign timer_irq      = timer_irq_ff;
  assign chip_reset_req = chip_reset_req_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_ctrl_ack_write(int bitpos);
    wr_ctrl && writedata[bitpos];
  endsequence

  sequence s_ctrl_read_answer;
    read && !waitrequest_ff && (address == ADDR_CTRL);
  endsequence

  a_count_step: assert property (@(posedge clock) disable iff (!resetn) // see RULE1
    (!chain_clear && chain_ff[1:0] != `RTW_PRESCALE_MAX) |=>
      $stable(chain_ff[`RTW_CNT_MSB:`RTW_CNT_LSB]))
    else $error("counter moved inside a prescale period");

  a_overflow_set: assert property (@(posedge clock) disable iff (!resetn) // see RULE4
    ovf_hit |=> overflow_flag_ff && chain_ff[`RTW_CNT_MSB:`RTW_CNT_LSB] == 8'h00)
    else $error("overflow flag not set on wrap");

  a_overflow_irq: assert property (@(posedge clock) disable iff (!resetn) // see RULE5
    (overflow_flag_ff && overflow_irq_enable_ff) |=> timer_irq_ff)
    else $error("overflow interrupt missing");

  a_overflow_ack: assert property (@(posedge clock) disable iff (!resetn) // see RULE6
    (s_ctrl_ack_write(`RTW_BIT_OVF_ACK) ##0 !ovf_hit) |=> !overflow_flag_ff)
    else $error("overflow acknowledge failed");

  a_ack_read_zero: assert property (@(posedge clock) disable iff (!resetn) // see RULE7
    s_ctrl_read_answer |-> readdata_ff[`RTW_BIT_OVF_ACK:`RTW_BIT_PER_ACK] == 2'h0)
    else $error("acknowledge bits read nonzero");

  a_periodic_set: assert property (@(posedge clock) disable iff (!resetn) // see RULE8
    per_hit |=> periodic_flag_ff ##1 (!$past(periodic_irq_enable_ff) || timer_irq_ff))
    else $error("periodic flag or interrupt missing");

  a_periodic_ack: assert property (@(posedge clock) disable iff (!resetn) // see RULE9
    (s_ctrl_ack_write(`RTW_BIT_PER_ACK) ##0 !per_hit) |=> !periodic_flag_ff)
    else $error("periodic acknowledge failed");

  a_rate_reset: assert property (@(posedge clock) // see RULE11
    !resetn |=> periodic_rate_select_ff == `RTW_RATE_RESET && !overflow_flag_ff && !periodic_irq_enable_ff)
    else $error("reset values wrong");

  a_watchdog_fire: assert property (@(posedge clock) disable iff (!resetn) // see RULE15
    wd_fire |=> chip_reset_req_ff && wd_cnt_ff == '0)
    else $error("watchdog timeout without reset request");

  a_watchdog_clear: assert property (@(posedge clock) disable iff (!resetn) // see RULE16
    (wd_clear && !chain_clear) |=> wd_cnt_ff == '0 && chain_ff == $past(chain_ff) + 1'b1)
    else $error("watchdog service misbehaved");

  a_stop_hold: assert property (@(posedge clock) disable iff (!resetn) // see RULE21
    stop_mode [*2] |-> chain_ff == '0 && delay_ff)
    else $error("chain runs in stop");

  a_answer_timing: assert property (@(posedge clock) disable iff (!resetn) // see RULE3
    (bus_ff == RTW_BUS_IDLE && read) |=> waitrequest_ff ##1 !waitrequest_ff ##1 waitrequest_ff)
    else $error("bus answer timing wrong");

endmodule : rtw_timer

`default_nettype wire

// ==== rtw_timer_tb.sv ====
// Self-checking testbench of the ripple timer with periodic interrupt and watchdog
`timescale 1ns/1ps
`default_nettype none
`include "rtw_cfg.svh"

module rtw_timer_tb
  import rtw_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic        clock;
  logic        resetn;
  logic [11:0] address;
  logic        read;
  logic        write;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        stop_mode;
  logic        user_byte_load;
  logic [7:0]  user_byte_data;
  logic        timer_irq;
  logic        chip_reset_req;
  int          err_total;
  int          compares;
  int          cyc;
  logic [31:0] q;
  localparam logic [11:0] A_CTRL = {`RTW_IDX_CTRL, 2'h0};
  localparam logic [11:0] A_CNT  = {`RTW_IDX_COUNT, 2'h0};
  localparam logic [11:0] A_SVC  = {`RTW_IDX_SERVICE, 2'h0};

  // Short power-on delay keeps the run brief
  rtw_timer #(.WD_PRESENT(1'b1), .LONG_DELAY(1'b0)) rtw_timer_inst (
    .clock(clock), .resetn(resetn), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .stop_mode(stop_mode), .user_byte_load(user_byte_load),
    .user_byte_data(user_byte_data), .timer_irq(timer_irq), .chip_reset_req(chip_reset_req)
  );

  // Clock of 10 ns and a free cycle counter
  always #5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks
  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask : chk_val

  task automatic chk_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %b got %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  // Avalon master: hold the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    address    <= a;
    writedata  <= {24'h0, d};
    byteenable <= be;
    read       <= ~wr;
    write      <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    chk_val("bus wait", 32'd3, 32'(n));
  endtask : bus

  // Wait for timer_irq to reach a level, bounded
  task automatic wait_irq(input logic lvl, input int lim);
    int n;
    n = 0;
    while (timer_irq !== lvl && n < lim) begin
      @(posedge clock);
      n++;
    end
    chk_bit("irq level", lvl, timer_irq);
  endtask : wait_irq

  // Synchronous reset, then time the power-on delay
  task automatic do_reset();
    int n;
    n = 0;
    resetn <= 1'b0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    while (chip_reset_req !== 1'b0 && n < 60) begin
      @(posedge clock);
      n++;
    end
    chk_bit("power-on delay", 1'b1, n >= 15 && n <= 19);
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_values();
    bus(1'b0, A_CTRL, 8'h0, 4'hf);
    chk_val("ctrl reset", 32'h03, q);
    bus(1'b1, A_CTRL, 8'h33, 4'h0);
    bus(1'b0, A_CTRL, 8'h0, 4'hf);
    chk_val("ctrl no lane", 32'h03, q);
    bus(1'b0, 12'h100, 8'h0, 4'hf);
    chk_val("unmapped", 32'h0, q);
  endtask : t_reset_values

  task automatic t_count_rate();
    logic [7:0] c1;
    int         t1;
    bus(1'b0, A_CNT, 8'h0, 4'hf);
    c1 = q[7:0];
    t1 = cyc;
    repeat (36) @(posedge clock);
    bus(1'b0, A_CNT, 8'h0, 4'hf);
    chk_val("count step", {24'h0, c1 + 8'((cyc - t1) / 4)}, q);
  endtask : t_count_rate

  task automatic t_overflow();
    bus(1'b1, A_CTRL, 8'h2f, 4'hf);
    wait_irq(1'b1, 1100);
    bus(1'b0, A_CTRL, 8'h0, 4'hf);
    chk_val("ovf flag set", 32'ha3, q);
    bus(1'b0, A_CNT, 8'h0, 4'hf);
    chk_val("count after wrap", 32'h0, q & 32'hf0);
    bus(1'b1, A_CTRL, 8'h03, 4'hf);
    wait_irq(1'b0, 4);
    bus(1'b0, A_CTRL, 8'h0, 4'hf);
    chk_val("flag write ignored", 32'h83, q);
    bus(1'b1, A_CTRL, 8'h0b, 4'hf);
    bus(1'b0, A_CTRL, 8'h0, 4'hf);
    chk_val("ovf ack", 32'h03, q);
  endtask : t_overflow

  task automatic t_periodic();
    int t1;
    bus(1'b1, A_SVC, 8'h00, 4'hf);
    bus(1'b1, A_CTRL, 8'h10, 4'hf);
    wait_irq(1'b1, 16500);
    t1 = cyc;
    bus(1'b0, A_CTRL, 8'h0, 4'hf);
    chk_val("periodic flag", 32'h50, q & 32'h7f);
    bus(1'b1, A_CTRL, 8'h10, 4'hf);
    bus(1'b0, A_CTRL, 8'h0, 4'hf);
    chk_val("per flag write", 32'h50, q & 32'h7f);
    bus(1'b1, A_CTRL, 8'h14, 4'hf);
    wait_irq(1'b0, 4);
    bus(1'b0, A_CTRL, 8'h0, 4'hf);
    chk_val("periodic ack", 32'h10, q & 32'h7f);
    wait_irq(1'b1, 16500);
    chk_val("periodic interval", 32'd16384, cyc - t1);
  endtask : t_periodic

  task automatic t_stop();
    stop_mode <= 1'b1;
    repeat (8) @(posedge clock);
    bus(1'b0, A_CNT, 8'h0, 4'hf);
    chk_val("count in stop", 32'h0, q);
    stop_mode <= 1'b0;
    repeat (20) @(posedge clock);
    chk_bit("stop exit no reset", 1'b0, chip_reset_req);
    bus(1'b0, A_CNT, 8'h0, 4'hf);
    chk_val("count after stop", 32'h0, q & 32'hfc);
  endtask : t_stop

  task automatic t_user_byte();
    @(posedge clock);
    user_byte_load <= 1'b1;
    user_byte_data <= 8'ha5;
    @(posedge clock);
    user_byte_load <= 1'b0;
    bus(1'b0, A_SVC, 8'h0, 4'hf);
    chk_val("user byte", 32'ha5, q);
    bus(1'b1, A_SVC, 8'h00, 4'hf);
    chk_bit("no watchdog reset", 1'b0, chip_reset_req);
    do_reset();
    bus(1'b0, A_SVC, 8'h0, 4'hf);
    chk_val("user byte kept", 32'ha5, q);
  endtask : t_user_byte

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    address = 12'h0;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hf;
    writedata = 32'h0;
    stop_mode = 1'b0;
    user_byte_load = 1'b0;
    user_byte_data = 8'h0;
    err_total = 0;
    compares = 0;
    cyc = 0;
    do_reset();
    t_reset_values();
    t_count_rate();
    t_overflow();
    t_periodic();
    t_stop();
    t_user_byte();
    complete_run();
  end

  // Watchdog against a hang: the scenarios need about 33,000 cycles
  initial begin
    #600000;
    err_total++;
    complete_run();
  end
endmodule : rtw_timer_tb

`default_nettype wire

// ==== rtw_user_byte.sv ====
// User nonvolatile byte behind the watchdog service location
`timescale 1ns/1ps
`default_nettype none

module rtw_user_byte (
  // Clock
  input  wire logic       clock,
  // Programming side
  input  wire logic       load,
  input  wire logic [7:0] load_data,
  // Read side
  input  wire logic       rd_en,
  output var  logic [7:0] rd_data_ff
);

  logic [7:0] store_ff;

  // Storage holds its value through every reset
  always_ff @(posedge clock) begin
    if (load) begin
      store_ff <= load_data;
    end
  end

  // Registered read port
  always_ff @(posedge clock) begin
    if (rd_en) begin
      rd_data_ff <= store_ff;
    end
  end

endmodule : rtw_user_byte

`default_nettype wire
